//--- src/scc_consts.svh
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// ==========================================
// Register numbers
`define R_IOFF 5'h00
`define R_ILIM 5'h01
`define R_DOFF 5'h02
`define R_DLIM 5'h03
`define R_BADVA 5'h08
`define R_COUNT 5'h09
`define R_CMP 5'h0B
`define R_STATUS 5'h0C
`define R_CAUSE 5'h0D
`define R_EPC 5'h0E
`define R_PROCESSOR_IDENTIFICATION 5'h0F
`define R_CONFIG 5'h10
`define R_REGION_CACHE_ALGORITHM 5'h11
`define R_FETCH_BREAKPOINT_ADDRESS 5'h12
`define R_DATA_BREAKPOINT_ADDRESS 5'h13
`define R_ECC 5'h1A
`define R_CERR 5'h1B
`define R_CACHE_TAG_LOW 5'h1C
`define R_ERREPC 5'h1E

// ==========================================
// Control word bit positions and reset values
`define ST_IE 0
`define ST_USER 1
`define ST_PUSER 2
`define ST_WATCH 3
`define ST_IVEC 4
`define ST_CU0 5
`define ST_CU1 6
`define ST_RST 32'h00000000
`define CA_CODE 2
`define CA_TIMER 15
`define REGION_CACHE_ALGORITHM_W 4
`define REGION_CACHE_ALGORITHM_UNCACHED 4'h2
`define REGION_CACHE_ALGORITHM_RST 32'h33333333
`define CONFIG_RST 32'h00000000
`define WORD_ZERO 32'h00000000
`define CNT_ONE 32'h00000001

// ==========================================
// Segments, mapping and vectors
`define TOP_CACHED 3'h4
`define TOP_UNCACHED 3'h5
`define TOP_UPPER 2'h3
`define KSEG_PMASK 32'h1FFFFFFF
`define VEC_GENERAL 32'h80000180
`define VEC_INTERRUPT 32'h80000200
`define VEC_CACHE_ERR 32'hA0000100

// ==========================================
// Exception codes
`define EXC_INT 5'h00
`define EXC_ADEL 5'h04
`define EXC_ADES 5'h05
`define EXC_WATCH 5'h17

`endif

//--- src/scc_pkg.sv
package scc_pkg;
   typedef enum logic [1:0] {REF_FETCH, REF_LOAD, REF_STORE} ref_kind_e;

   typedef struct packed {
      logic valid;
      ref_kind_e kind;
      logic [31:0] vaddr;
      logic [31:0] pc;
   } ref_s;

   typedef struct packed {
      logic valid;
      logic fault;
      logic uncached;
      logic [3:0] attr;
      logic [31:0] paddr;
   } xlate_s;

   typedef struct packed {
      logic valid;
      logic cache_err;
      logic [4:0] code;
      logic [31:0] pc;
      logic [31:0] badva;
   } exc_s;
endpackage

//--- src/system_control_coprocessor.sv
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.svh"

// Summary of operation
// - Cycle counter advances every second clock.
// - Counter equal to match value requests interrupt.
// - Two levels; kernel on reset and exception.
// - Kernel reaches everything; floating-point enable setting.
// - User limited; setting grants user coprocessor access.
// - 0x80000000 segment is cached unmapped kernel.
// - 0xA0000000-0xBFFFFFFF is uncached unmapped kernel.
// - Upper 1GB kernel unmapped; low 2GB user.
// - Kernel segments kernel only; user region both.
// - User references checked against matching limit.
// - In-limit reference adds matching offset.
// - Out-of-limit reference blocked, exception raised.
// - Kernel segments use fixed mapping, no check.
// - Enabled watch match raises exception.
// - Optional separate interrupt vector.
// - Address exception captures faulting address.
// - Record restart PC and cause; cache error separate.
// - Cache attribute per 512MB region by top bits.
// - Unused register numbers are not implemented.
module system_control_coprocessor #(
   parameter logic [31:0] PROC_ID = 32'h00005A5A // Arbitrary identification value.
) (
   input wire logic clock, // Pipeline clock.
   input wire logic nrst, // Synchronous reset, active low.
   input wire logic [4:0] reg_addr, // Register number.
   input wire logic [31:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   output logic [31:0] reg_rdata, // Read data, cycle after strobe.
   input wire scc_pkg::ref_s ref_in, // Address reference from pipeline.
   output scc_pkg::xlate_s xlate_out, // Translation result.
   input wire scc_pkg::exc_s exc_in, // Exception from pipeline.
   input wire logic exc_return, // Return from exception.
   input wire logic [31:0] cache_err_in, // Cache error details.
   output logic exc_taken, // Exception accepted pulse.
   output logic [31:0] exc_vector, // Handler address.
   output logic kernel_mode, // Kernel level active.
   output logic cp0_usable, // Coprocessor-zero access allowed.
   output logic cp1_usable, // Floating-point access allowed.
   output logic timer_irq // Timer interrupt request.
);

   // ==========================================
   // Register storage
   logic [31:0] ioff_q, ilim_q, doff_q, dlim_q, badva_q, count_q, cmp_q;
   logic [31:0] status_q, epc_q, config_q, region_cache_algorithm_q, fetch_breakpoint_address_q, data_breakpoint_address_q;
   logic [31:0] ecc_q, cerr_q, cache_tag_low_q, errepc_q;
   logic [4:0] code_q;
   logic half_q, timer_q;
   logic cnt_wr, cmp_wr, timer_set;

   assign cnt_wr = reg_wr && reg_addr == `R_COUNT;
   assign cmp_wr = reg_wr && reg_addr == `R_CMP;

   // ==========================================
   // Reference decode
   logic is_fetch, seg_user, in_bound, watch_hit, seg_fault, bound_fault;
   logic ref_fault, addr_fault;
   logic [31:0] lim, off, paddr_d;
   logic [3:0] attr;
   logic [4:0] ref_code;

   always_comb begin
      is_fetch = ref_in.kind == scc_pkg::REF_FETCH;
      seg_user = ~ref_in.vaddr[31];
      lim = is_fetch ? ilim_q : dlim_q;
      off = is_fetch ? ioff_q : doff_q;
      in_bound = ref_in.vaddr < lim;
      watch_hit = status_q[`ST_WATCH] && (is_fetch ?
         ref_in.vaddr[31:2] == fetch_breakpoint_address_q[31:2] : ref_in.vaddr[31:2] == data_breakpoint_address_q[31:2]);
      seg_fault = status_q[`ST_USER] && !seg_user;
      bound_fault = seg_user && !in_bound;
      addr_fault = seg_fault || bound_fault;
      ref_fault = ref_in.valid && (addr_fault || watch_hit);
      attr = region_cache_algorithm_q[{ref_in.vaddr[31:29], 2'b00} +: `REGION_CACHE_ALGORITHM_W];
      if (seg_user) begin
         paddr_d = ref_in.vaddr + off;
      end else if (ref_in.vaddr[31:30] == `TOP_UPPER) begin
         paddr_d = ref_in.vaddr;
      end else begin
         paddr_d = ref_in.vaddr & `KSEG_PMASK;
      end
      if (addr_fault) begin
         ref_code = (ref_in.kind == scc_pkg::REF_STORE) ? `EXC_ADES : `EXC_ADEL;
      end else begin
         ref_code = `EXC_WATCH;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         xlate_out <= '0;
      end else begin
         xlate_out.valid <= ref_in.valid && !ref_fault;
         xlate_out.fault <= ref_fault;
         xlate_out.uncached <= ref_in.vaddr[31:29] == `TOP_UNCACHED
            || attr == `REGION_CACHE_ALGORITHM_UNCACHED;
         xlate_out.attr <= attr;
         xlate_out.paddr <= ref_fault ? `WORD_ZERO : paddr_d;
      end
   end

   // ==========================================
   // Exception acceptance
   logic take, take_cerr, take_addr;
   logic [4:0] take_code;
   logic [31:0] take_pc, take_badva;

   always_comb begin
      take = exc_in.valid || ref_fault;
      take_cerr = exc_in.valid && exc_in.cache_err;
      take_code = exc_in.valid ? exc_in.code : ref_code;
      take_pc = exc_in.valid ? exc_in.pc : ref_in.pc;
      take_badva = exc_in.valid ? exc_in.badva : ref_in.vaddr;
      take_addr = take && (take_code == `EXC_ADEL || take_code == `EXC_ADES);
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         exc_taken <= 1'b0;
         exc_vector <= `VEC_GENERAL;
      end else begin
         exc_taken <= take;
         if (take_cerr) begin
            exc_vector <= `VEC_CACHE_ERR;
         end else if (take && take_code == `EXC_INT && status_q[`ST_IVEC]) begin
            exc_vector <= `VEC_INTERRUPT;
         end else if (take) begin
            exc_vector <= `VEC_GENERAL;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         status_q <= `ST_RST;
      end else if (take) begin
         status_q[`ST_PUSER] <= status_q[`ST_USER];
         status_q[`ST_USER] <= 1'b0;
      end else if (exc_return) begin
         status_q[`ST_USER] <= status_q[`ST_PUSER];
      end else if (reg_wr && reg_addr == `R_STATUS) begin
         status_q <= reg_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         epc_q <= `WORD_ZERO;
         errepc_q <= `WORD_ZERO;
         cerr_q <= `WORD_ZERO;
         code_q <= `EXC_INT;
      end else begin
         if (take && !take_cerr) begin
            epc_q <= take_pc;
         end else if (!take && reg_wr && reg_addr == `R_EPC) begin
            epc_q <= reg_wdata;
         end
         if (take_cerr) begin
            errepc_q <= take_pc;
            cerr_q <= cache_err_in;
         end else if (reg_wr && reg_addr == `R_ERREPC) begin
            errepc_q <= reg_wdata;
         end
         if (take) begin
            code_q <= take_code;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         badva_q <= `WORD_ZERO;
      end else if (take_addr) begin
         badva_q <= take_badva;
      end
   end

   // ==========================================
   // Cycle counter and timer
   // every second cycle
   always_ff @(posedge clock) begin
      if (!nrst) begin
         half_q <= 1'b0;
         count_q <= `WORD_ZERO;
      end else begin
         half_q <= !half_q;
         if (cnt_wr) begin
            count_q <= reg_wdata;
         end else if (half_q) begin
            count_q <= count_q + `CNT_ONE;
         end
      end
   end

   assign timer_set = half_q && !cnt_wr && (count_q + `CNT_ONE) == cmp_q;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         timer_q <= 1'b0;
      end else if (timer_set) begin
         timer_q <= 1'b1;
      end else if (cmp_wr) begin
         timer_q <= 1'b0;
      end
   end

   assign timer_irq = timer_q;
   assign kernel_mode = !status_q[`ST_USER];
   assign cp0_usable = kernel_mode || status_q[`ST_CU0];
   assign cp1_usable = status_q[`ST_CU1];

   // ==========================================
   // Software writable registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ioff_q <= `WORD_ZERO;
         ilim_q <= `WORD_ZERO;
         doff_q <= `WORD_ZERO;
         dlim_q <= `WORD_ZERO;
         cmp_q <= `WORD_ZERO;
         config_q <= `CONFIG_RST;
         region_cache_algorithm_q <= `REGION_CACHE_ALGORITHM_RST;
         fetch_breakpoint_address_q <= `WORD_ZERO;
         data_breakpoint_address_q <= `WORD_ZERO;
         ecc_q <= `WORD_ZERO;
         cache_tag_low_q <= `WORD_ZERO;
      end else if (reg_wr) begin
         if (reg_addr == `R_IOFF) begin
            ioff_q <= reg_wdata;
         end else if (reg_addr == `R_ILIM) begin
            ilim_q <= reg_wdata;
         end else if (reg_addr == `R_DOFF) begin
            doff_q <= reg_wdata;
         end else if (reg_addr == `R_DLIM) begin
            dlim_q <= reg_wdata;
         end else if (reg_addr == `R_CMP) begin
            cmp_q <= reg_wdata;
         end else if (reg_addr == `R_CONFIG) begin
            config_q <= reg_wdata;
         end else if (reg_addr == `R_REGION_CACHE_ALGORITHM) begin
            region_cache_algorithm_q <= reg_wdata;
         end else if (reg_addr == `R_FETCH_BREAKPOINT_ADDRESS) begin
            fetch_breakpoint_address_q <= reg_wdata;
         end else if (reg_addr == `R_DATA_BREAKPOINT_ADDRESS) begin
            data_breakpoint_address_q <= reg_wdata;
         end else if (reg_addr == `R_ECC) begin
            ecc_q <= reg_wdata;
         end else if (reg_addr == `R_CACHE_TAG_LOW) begin
            cache_tag_low_q <= reg_wdata;
         end
      end
   end

   // ==========================================
   // Read port
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = `WORD_ZERO;
      if (reg_addr == `R_IOFF) begin
         rd_mux = ioff_q;
      end else if (reg_addr == `R_ILIM) begin
         rd_mux = ilim_q;
      end else if (reg_addr == `R_DOFF) begin
         rd_mux = doff_q;
      end else if (reg_addr == `R_DLIM) begin
         rd_mux = dlim_q;
      end else if (reg_addr == `R_BADVA) begin
         rd_mux = badva_q;
      end else if (reg_addr == `R_COUNT) begin
         rd_mux = count_q;
      end else if (reg_addr == `R_CMP) begin
         rd_mux = cmp_q;
      end else if (reg_addr == `R_STATUS) begin
         rd_mux = status_q;
      end else if (reg_addr == `R_CAUSE) begin
         rd_mux[`CA_TIMER] = timer_q;
         rd_mux[`CA_CODE +: 5] = code_q;
      end else if (reg_addr == `R_EPC) begin
         rd_mux = epc_q;
      end else if (reg_addr == `R_PROCESSOR_IDENTIFICATION) begin
         rd_mux = PROC_ID;
      end else if (reg_addr == `R_CONFIG) begin
         rd_mux = config_q;
      end else if (reg_addr == `R_REGION_CACHE_ALGORITHM) begin
         rd_mux = region_cache_algorithm_q;
      end else if (reg_addr == `R_FETCH_BREAKPOINT_ADDRESS) begin
         rd_mux = fetch_breakpoint_address_q;
      end else if (reg_addr == `R_DATA_BREAKPOINT_ADDRESS) begin
         rd_mux = data_breakpoint_address_q;
      end else if (reg_addr == `R_ECC) begin
         rd_mux = ecc_q;
      end else if (reg_addr == `R_CERR) begin
         rd_mux = cerr_q;
      end else if (reg_addr == `R_CACHE_TAG_LOW) begin
         rd_mux = cache_tag_low_q;
      end else if (reg_addr == `R_ERREPC) begin
         rd_mux = errepc_q;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         reg_rdata <= `WORD_ZERO;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : `WORD_ZERO;
      end
   end

   // ==========================================
   // Checks
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // The first step must lie after reset so that the past count is a live one.
   sequence no_cnt_wr2;
      (nrst && !cnt_wr) ##1 !cnt_wr;
   endsequence
   count_step_a: assert property (
      no_cnt_wr2 |=> count_q == $past(count_q, 2) + `CNT_ONE)
      else $error("counter did not advance once per two cycles");
   timer_match_a: assert property (
      timer_set |=> timer_irq ##1 (timer_irq || $past(cmp_wr)))
      else $error("timer request missing after match");
   timer_hold_a: assert property (
      timer_irq && !cmp_wr |=> timer_irq)
      else $error("timer request dropped without a write");
   timer_clear_a: assert property (
      cmp_wr && !timer_set |=> !timer_irq)
      else $error("timer request survived a match value write");
   exc_kernel_a: assert property (
      take |=> kernel_mode && exc_taken)
      else $error("exception did not enter kernel level");
   user_fault_a: assert property (
      ref_in.valid && !kernel_mode && ref_in.vaddr[31] && !exc_in.valid
      |=> xlate_out.fault && !xlate_out.valid && badva_q == $past(ref_in.vaddr))
      else $error("user kernel-segment reference not faulted");
   fetch_map_a: assert property (
      ref_in.valid && is_fetch && !ref_in.vaddr[31] && ref_in.vaddr < ilim_q
      && !watch_hit |=> xlate_out.valid
      && xlate_out.paddr == $past(ref_in.vaddr) + $past(ioff_q))
      else $error("in-limit fetch translated wrongly");
   load_bound_a: assert property (
      ref_in.valid && ref_in.kind == scc_pkg::REF_LOAD && !ref_in.vaddr[31]
      && ref_in.vaddr >= dlim_q |=> !xlate_out.valid && exc_taken)
      else $error("out-of-limit load was not refused");
   uncached_seg_a: assert property (
      ref_in.valid && kernel_mode && ref_in.vaddr[31:29] == `TOP_UNCACHED && !watch_hit
      |=> xlate_out.uncached && xlate_out.paddr == ($past(ref_in.vaddr) & `KSEG_PMASK))
      else $error("uncached kernel segment mapped wrongly");
   int_vector_a: assert property (
      exc_in.valid && !exc_in.cache_err && exc_in.code == `EXC_INT
      && status_q[`ST_IVEC] |=> exc_vector == `VEC_INTERRUPT)
      else $error("interrupt not sent to its own vector");
   cache_err_pc_a: assert property (
      exc_in.valid && exc_in.cache_err
      |=> errepc_q == $past(exc_in.pc) && epc_q == $past(epc_q))
      else $error("cache error PC saved in the wrong place");

endmodule
`default_nettype wire

//--- dv/pipe_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Integer pipeline stand-in issuing references and exceptions
module pipe_model (
   input wire logic clock, // Pipeline clock.
   output var scc_pkg::ref_s ref_in, // Address reference.
   output var scc_pkg::exc_s exc_in, // Exception report.
   output var logic exc_return, // Return pulse.
   output var logic [31:0] cache_err_in // Cache error details.
);
   initial begin
      ref_in = '{1'b0, scc_pkg::REF_FETCH, 32'h00000000, 32'h00000000};
      exc_in = '{1'b0, 1'b0, 5'h00, 32'h00000000, 32'h00000000};
      exc_return = 1'b0;
      cache_err_in = 32'h00000000;
   end

   // Idle reference address and PC take the inverted address, kind is kept, so stale values cannot pass for live ones.
   task automatic send_ref(input scc_pkg::ref_kind_e kind, input logic [31:0] va);
      @(posedge clock);
      ref_in <= '{1'b1, kind, va, va ^ 32'h00F0F0F0};
      @(posedge clock);
      ref_in <= '{1'b0, kind, ~va, ~va};
   endtask

   task automatic send_exc(input logic cerr, input logic [4:0] code, input logic [31:0] pc,
      input logic [31:0] info);
      @(posedge clock);
      exc_in <= '{1'b1, cerr, code, pc, info};
      cache_err_in <= info;
      @(posedge clock);
      exc_in <= '{1'b0, ~cerr, ~code, ~pc, 32'hFFFFFFFF};
      cache_err_in <= ~info;
   endtask

   task automatic send_ret();
      @(posedge clock);
      exc_return <= 1'b1;
      @(posedge clock);
      exc_return <= 1'b0;
   endtask
endmodule

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.svh"

module tb_top;
   localparam logic [31:0] ID = 32'h0000C3C3; // Arbitrary identification value.
   logic clock, nrst, reg_wr, reg_rd, exc_return, exc_taken;
   logic kernel_mode, cp0_usable, cp1_usable, timer_irq;
   logic [4:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, cache_err_in, exc_vector, v, w;
   scc_pkg::ref_s ref_in;
   scc_pkg::xlate_s xlate_out;
   scc_pkg::exc_s exc_in;
   int miscompares = 0;
   int compares = 0;
   int n;
   logic [4:0] rw_list [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0E, 5'h11, 5'h12, 5'h13,
      5'h1A, 5'h1C, 5'h1E};
   logic [4:0] unused_list [13] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h0A, 5'h14, 5'h15,
      5'h16, 5'h17, 5'h18, 5'h19, 5'h1D, 5'h1F};

   system_control_coprocessor #(.PROC_ID(ID)) uut (.clock(clock), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ref_in(ref_in), .xlate_out(xlate_out), .exc_in(exc_in),
      .exc_return(exc_return), .cache_err_in(cache_err_in), .exc_taken(exc_taken),
      .exc_vector(exc_vector), .kernel_mode(kernel_mode), .cp0_usable(cp0_usable),
      .cp1_usable(cp1_usable), .timer_irq(timer_irq));

   pipe_model pipe (.clock(clock), .ref_in(ref_in), .exc_in(exc_in),
      .exc_return(exc_return), .cache_err_in(cache_err_in));

   // ==========================================
   // Register port and comparison tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      q = reg_rdata;
   endtask

   task automatic end_sim();
      if (miscompares == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========================================
   // One reference with its expected translation or fault
   task automatic t_ref(input logic [31:0] st, input scc_pkg::ref_kind_e k,
      input logic [31:0] va, input logic flt, input logic [31:0] pa, input logic unc);
      logic [31:0] q;
      wr(`R_STATUS, st);
      pipe.send_ref(k, va);
      #1;
      chk(xlate_out.valid, !flt);
      chk(xlate_out.fault, flt);
      chk(exc_taken, flt);
      if (flt) begin
         chk(xlate_out.paddr, 32'h00000000);
         chk(kernel_mode, 1'b1);
         rd(`R_BADVA, q);
         chk(q, va);
         rd(`R_CAUSE, q);
         chk(q[6:2], (k == scc_pkg::REF_STORE) ? `EXC_ADES : `EXC_ADEL);
      end else begin
         chk(xlate_out.paddr, pa);
         chk(xlate_out.uncached, unc);
         chk(xlate_out.attr, {1'b0, va[31:29]});
      end
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   initial begin
      #200000;
      miscompares++;
      end_sim();
   end

   initial begin
      nrst = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      #1;
      chk(kernel_mode, 1'b1);
      chk(cp0_usable, 1'b1);
      chk(exc_vector, `VEC_GENERAL);
      rd(`R_REGION_CACHE_ALGORITHM, v);
      chk(v, `REGION_CACHE_ALGORITHM_RST);
      @(posedge clock);
      #1;
      chk(reg_rdata, 32'h00000000);
      rd(`R_STATUS, v);
      chk(v, `ST_RST);
      // ==========================================
      // Register map: read-write, read-only and absent numbers
      for (int i = 0; i < 11; i++) begin
         wr(rw_list[i], 32'hA5000000 | 32'(i));
         rd(rw_list[i], v);
         chk(v, 32'hA5000000 | 32'(i));
      end
      wr(`R_PROCESSOR_IDENTIFICATION, 32'hFFFFFFFF);
      rd(`R_PROCESSOR_IDENTIFICATION, v);
      chk(v, ID);
      wr(`R_BADVA, 32'hFFFFFFFF);
      rd(`R_BADVA, v);
      chk(v, 32'h00000000);
      wr(`R_CERR, 32'hFFFFFFFF);
      rd(`R_CERR, v);
      chk(v, 32'h00000000);
      for (int i = 0; i < 13; i++) begin
         wr(unused_list[i], 32'hFFFFFFFF);
         rd(unused_list[i], v);
         chk(v, 32'h00000000);
      end
      // ==========================================
      // Counter rate: twenty clocks between samples
      rd(`R_COUNT, v);
      repeat (18) @(posedge clock);
      rd(`R_COUNT, w);
      chk(w - v, 32'h0000000A);
      // ==========================================
      // Privilege levels, usable outputs, return and exception records
      wr(`R_STATUS, 32'h00000002);
      #1;
      chk(kernel_mode, 1'b0);
      chk(cp0_usable, 1'b0);
      chk(cp1_usable, 1'b0);
      wr(`R_STATUS, 32'h00000062);
      #1;
      chk(cp0_usable, 1'b1);
      chk(cp1_usable, 1'b1);
      pipe.send_exc(1'b0, `EXC_INT, 32'h00400100, 32'h00000000);
      #1;
      chk(exc_taken, 1'b1);
      chk(kernel_mode, 1'b1);
      chk(exc_vector, `VEC_GENERAL);
      rd(`R_EPC, v);
      chk(v, 32'h00400100);
      rd(`R_CAUSE, v);
      chk(v[6:2], `EXC_INT);
      pipe.send_ret();
      #1;
      chk(kernel_mode, 1'b0);
      pipe.send_exc(1'b1, `EXC_INT, 32'h00400200, 32'h0000C0DE);
      #1;
      chk(exc_vector, `VEC_CACHE_ERR);
      rd(`R_ERREPC, v);
      chk(v, 32'h00400200);
      rd(`R_CERR, v);
      chk(v, 32'h0000C0DE);
      wr(`R_STATUS, 32'h00000010);
      pipe.send_exc(1'b0, `EXC_INT, 32'h00400300, 32'h00000000);
      #1;
      chk(exc_vector, `VEC_INTERRUPT);
      @(posedge clock);
      #1;
      chk(exc_vector, `VEC_INTERRUPT);
      pipe.send_exc(1'b0, `EXC_ADEL, 32'h00400400, 32'h12345678);
      #1;
      chk(exc_vector, `VEC_GENERAL);
      rd(`R_BADVA, v);
      chk(v, 32'h12345678);
      rd(`R_EPC, v);
      chk(v, 32'h00400400);
      // ==========================================
      // Translation, segments and bounds
      wr(`R_IOFF, 32'h00100000);
      wr(`R_ILIM, 32'h00008000);
      wr(`R_DOFF, 32'h00200000);
      wr(`R_DLIM, 32'h00004000);
      wr(`R_REGION_CACHE_ALGORITHM, 32'h76543210);
      t_ref(32'h00000002, scc_pkg::REF_FETCH, 32'h00001000, 1'b0, 32'h00101000, 1'b0);
      t_ref(32'h00000002, scc_pkg::REF_LOAD, 32'h00002000, 1'b0, 32'h00202000, 1'b0);
      t_ref(32'h00000002, scc_pkg::REF_STORE, 32'h00004000, 1'b1, 32'h00000000, 1'b0);
      t_ref(32'h00000002, scc_pkg::REF_FETCH, 32'h00008000, 1'b1, 32'h00000000, 1'b0);
      t_ref(32'h00000002, scc_pkg::REF_LOAD, 32'h80000010, 1'b1, 32'h00000000, 1'b0);
      t_ref(32'h00000002, scc_pkg::REF_STORE, 32'hC0000000, 1'b1, 32'h00000000, 1'b0);
      t_ref(32'h00000000, scc_pkg::REF_LOAD, 32'h80001234, 1'b0, 32'h00001234, 1'b0);
      t_ref(32'h00000000, scc_pkg::REF_STORE, 32'hBFFFFFFC, 1'b0, 32'h1FFFFFFC, 1'b1);
      t_ref(32'h00000000, scc_pkg::REF_FETCH, 32'hC0000040, 1'b0, 32'hC0000040, 1'b0);
      t_ref(32'h00000000, scc_pkg::REF_LOAD, 32'h00002000, 1'b0, 32'h00202000, 1'b0);
      // ==========================================
      // Watch breakpoints on a word match
      wr(`R_FETCH_BREAKPOINT_ADDRESS, 32'h80000100);
      wr(`R_DATA_BREAKPOINT_ADDRESS, 32'h80000200);
      t_ref(32'h00000000, scc_pkg::REF_FETCH, 32'h80000102, 1'b0, 32'h00000102, 1'b0);
      wr(`R_STATUS, 32'h00000008);
      pipe.send_ref(scc_pkg::REF_FETCH, 32'h80000102);
      #1;
      chk(exc_taken, 1'b1);
      rd(`R_CAUSE, v);
      chk(v[6:2], `EXC_WATCH);
      wr(`R_STATUS, 32'h00000008);
      pipe.send_ref(scc_pkg::REF_STORE, 32'h80000200);
      #1;
      chk(exc_taken, 1'b1);
      // ==========================================
      // Timer match request, held until the match value is written
      wr(`R_COUNT, 32'h00000100);
      wr(`R_CMP, 32'h00000014);
      #1;
      chk(timer_irq, 1'b0);
      wr(`R_COUNT, 32'h00000000);
      n = 0;
      while (timer_irq !== 1'b1 && n < 100) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(n >= 38 && n <= 42, 1'b1);
      repeat (4) @(posedge clock);
      #1;
      chk(timer_irq, 1'b1);
      rd(`R_CAUSE, v);
      chk(v[`CA_TIMER], 1'b1);
      wr(`R_CMP, 32'hFFFF0000);
      #1;
      chk(timer_irq, 1'b0);
      end_sim();
   end
endmodule

`default_nettype wire
